// >>> rtl/ssp_spi_port.v
// Contract
// - Eight-bit shifter, MSB out, LSB in
// - Shift out one edge, capture opposite
// - Unselected slave ignores bus, drives nothing
// - Same polarity; master starts the clock
// - Out feeds in; eight clocks swap bytes
// - Full byte copied to buffer, done flag
// - Buffer write loads shifter too
// - Buffer full set on receive, read clears
// - Write while busy discarded, collision sticks
// - Shifter reachable only via buffer
// - Control fields pick mode, edges, rate
// - Runs only while enable bit set
// - Reload register drives baud generator
// - Status: upper two writable, lower read-only
// - Master transfer starts on buffer write
// - Master rates: /4, /16, /64, T2/2, reload
// - Slave shifts on external clock, flags done
`timescale 1ns/1ps
`default_nettype none
`include "ssp_defines.vh"
module ssp_spi_port (
    // APB clock and reset
    input wire pclk,
    input wire presetn,
    // APB slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output wire [31:0] prdata,
    output wire pready,
    output wire pslverr,
    // Timer tick for the timer rate option
    input wire t2_tick,
    // Serial clock pin
    input wire sck_in,
    output reg sck_out,
    output wire sck_oe,
    // Serial data
    input wire sdi,
    output wire sdo_out,
    output wire sdo_oe,
    // Slave select, active low
    input wire ss_n,
    // Transfer done event flag level
    output wire transfer_done_flag
);
    ////////////////////////////////////////////////////////////////////
    // Registers
    reg [7:0] serial_control_one;
    reg [7:0] serial_control_three;
    reg [1:0] stat_cfg_reg;
    reg [7:0] rate_reload_reg;
    reg [7:0] data_buffer_reg;
    reg [7:0] transfer_shift_reg;
    reg buffer_full_flag;
    reg write_collision_flag;
    reg done_reg;
    reg out_bit_reg;
    reg [3:0] bit_cnt_reg;
    reg busy_reg;
    reg phase_reg;
    reg [31:0] rdata_reg;

    wire port_enable_bit = serial_control_one[`SSP_CON1_EN];
    wire ckp = serial_control_one[`SSP_CON1_CKP];
    wire [3:0] mode = serial_control_one[3:0];
    wire cke = stat_cfg_reg[0];
    wire smp = stat_cfg_reg[1];
    wire boen = serial_control_three[`SSP_CON3_BOEN];
    wire is_master = (mode <= `SSP_MODE_MT2) || (mode == `SSP_MODE_MADD);
    wire ss_used = (mode == `SSP_MODE_SSS);

    ////////////////////////////////////////////////////////////////////
    // APB decode; single-cycle access, never waits
    wire acc = psel & penable;
    wire wr = acc & pwrite;
    wire rd = acc & ~pwrite;
    wire hit_buf = (paddr == `SSP_OFF_BUF);
    wire hit_stat = (paddr == `SSP_OFF_STAT);
    wire hit_con1 = (paddr == `SSP_OFF_CON1);
    wire hit_con3 = (paddr == `SSP_OFF_CON3);
    wire hit_add = (paddr == `SSP_OFF_ADD);
    wire hit_flag = (paddr == `SSP_OFF_FLAG);
    wire mapped = hit_buf | hit_stat | hit_con1 | hit_con3 | hit_add |
        hit_flag;
    assign pready = 1'b1;
    assign pslverr = acc & ~mapped;
    assign prdata = rdata_reg;

    wire [7:0] stat_val = {stat_cfg_reg, 5'h00, buffer_full_flag};
    wire [7:0] con1_val = {write_collision_flag, serial_control_one[6:0]};

    // Read data registered in the setup cycle so it is valid in access
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata_reg <= 32'h00000000;
        end else if (psel & ~penable & ~pwrite) begin
            case (paddr)
                `SSP_OFF_BUF: rdata_reg <= {24'h000000, data_buffer_reg};
                `SSP_OFF_STAT: rdata_reg <= {24'h000000, stat_val};
                `SSP_OFF_CON1: rdata_reg <= {24'h000000, con1_val};
                `SSP_OFF_CON3: rdata_reg <= {24'h000000,
                    serial_control_three};
                `SSP_OFF_ADD: rdata_reg <= {24'h000000, rate_reload_reg};
                `SSP_OFF_FLAG: rdata_reg <= {31'h00000000, done_reg};
                default: rdata_reg <= 32'h00000000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Serial clock timing sources
    wire half_tick;
    wire s_rise;
    wire s_fall;

    ssp_rate_gen u_rate (
        .pclk(pclk),
        .presetn(presetn),
        .run(busy_reg & is_master & port_enable_bit),
        .mode(mode),
        .reload(rate_reload_reg),
        .t2_tick(t2_tick),
        .half_tick(half_tick)
    );

    ssp_edge_det u_edge (
        .pclk(pclk),
        .presetn(presetn),
        .sig(sck_in),
        .rise(s_rise),
        .fall(s_fall)
    );

    // Slave: selected when select is low or select unused
    wire selected = ~ss_used | ~ss_n;
    // Leading edge leaves idle level; trailing edge returns to it
    wire s_lead = ckp ? s_fall : s_rise;
    wire s_trail = ckp ? s_rise : s_fall;
    // CKE set: data changes on trailing edge, sampled on leading edge
    wire s_shift = port_enable_bit & ~is_master & selected &
        (cke ? s_trail : s_lead);
    wire s_sample = port_enable_bit & ~is_master & selected &
        (cke ? s_lead : s_trail);

    // Master: phase 0 half ends at leading edge, phase 1 at trailing
    wire m_lead = busy_reg & is_master & half_tick & ~phase_reg;
    wire m_trail = busy_reg & is_master & half_tick & phase_reg;
    wire m_shift = cke ? m_trail : m_lead;
    wire m_sample_mid = cke ? m_lead : m_trail;
    // SMP set: sample at end of output time, on the next shift edge
    wire m_sample = smp ? m_shift : m_sample_mid;

    wire do_shift = is_master ? m_shift : s_shift;
    wire do_sample = is_master ? m_sample : s_sample;
    wire last_bit = (bit_cnt_reg == 4'h7);
    wire buf_wr = wr & hit_buf;
    wire buf_rd = rd & hit_buf;
    wire in_xfer = is_master ? busy_reg : (bit_cnt_reg != 4'h0);
    wire byte_done = do_sample & last_bit;
    wire wr_ok = buf_wr & ~write_collision_flag & ~in_xfer &
        (boen | ~is_master | 1'b1);

    ////////////////////////////////////////////////////////////////////
    // Control registers; disabling resets the transfer engine
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            serial_control_one <= `SSP_CON1_RST;
            serial_control_three <= 8'h00;
            stat_cfg_reg <= 2'b00;
            rate_reload_reg <= `SSP_ADD_RST;
        end else if (wr) begin
            if (hit_con1) begin
                serial_control_one <= {1'b0, pwdata[6:0]};
            end
            if (hit_stat) begin
                stat_cfg_reg <= pwdata[7:6];
            end
            if (hit_con3) begin
                serial_control_three <= pwdata[7:0];
            end
            if (hit_add) begin
                rate_reload_reg <= pwdata[7:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Shift engine
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            transfer_shift_reg <= 8'h00;
            data_buffer_reg <= 8'h00;
            bit_cnt_reg <= 4'h0;
            busy_reg <= 1'b0;
            phase_reg <= 1'b0;
            out_bit_reg <= 1'b0;
        end else if (!port_enable_bit ||
            (ss_used && ss_n && !is_master)) begin
            // Select released mid-byte realigns the bit counter
            bit_cnt_reg <= 4'h0;
            busy_reg <= 1'b0;
            phase_reg <= 1'b0;
            if (wr_ok) begin
                data_buffer_reg <= pwdata[7:0];
                transfer_shift_reg <= pwdata[7:0];
                out_bit_reg <= pwdata[7];
            end
        end else begin
            if (wr_ok) begin
                // Same byte into buffer and shifter at once
                data_buffer_reg <= pwdata[7:0];
                transfer_shift_reg <= pwdata[7:0];
                out_bit_reg <= pwdata[7];
                busy_reg <= is_master;
                phase_reg <= 1'b0;
            end
            if (is_master && half_tick && busy_reg) begin
                phase_reg <= ~phase_reg;
            end
            if (do_sample) begin
                // MSB leaves, incoming bit enters at LSB
                transfer_shift_reg <= {transfer_shift_reg[6:0], sdi};
                bit_cnt_reg <= last_bit ? 4'h0 : bit_cnt_reg + 4'h1;
            end
            if (do_shift && (bit_cnt_reg != 4'h0 || cke == 1'b0)) begin
                out_bit_reg <= transfer_shift_reg[7];
            end
            if (byte_done) begin
                // Whole byte lands in buffer, swap is complete
                data_buffer_reg <= {transfer_shift_reg[6:0], sdi};
                busy_reg <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Flags: hardware set wins over software clear
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            buffer_full_flag <= 1'b0;
            write_collision_flag <= 1'b0;
            done_reg <= 1'b0;
        end else begin
            if (byte_done) begin
                buffer_full_flag <= 1'b1;
            end else if (buf_rd) begin
                buffer_full_flag <= 1'b0;
            end
            if (buf_wr && (in_xfer || write_collision_flag)) begin
                write_collision_flag <= 1'b1;
            end else if (wr && hit_con1 && !pwdata[`SSP_CON1_WRITE_COLLISION_FLAG]) begin
                write_collision_flag <= 1'b0;
            end
            if (byte_done) begin
                done_reg <= 1'b1;
            end else if (wr && hit_flag && pwdata[0]) begin
                done_reg <= 1'b0;
            end
        end
    end
    assign transfer_done_flag = done_reg;

    ////////////////////////////////////////////////////////////////////
    // Master serial clock: idle level unless mid-transfer
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sck_out <= 1'b0;
        end else if (!busy_reg || !is_master) begin
            sck_out <= ckp;
        end else if (half_tick) begin
            sck_out <= phase_reg ? ckp : ~ckp;
        end
    end

    // Pin ownership follows enable and mode
    assign sck_oe = port_enable_bit & is_master;
    assign sdo_oe = port_enable_bit & (is_master | selected);
    assign sdo_out = out_bit_reg;
endmodule
`default_nettype wire

// >>> rtl/ssp_defines.vh
`ifndef SSP_DEFINES_VH
`define SSP_DEFINES_VH

// Register byte offsets on APB
`define SSP_OFF_BUF 12'h000
`define SSP_OFF_STAT 12'h004
`define SSP_OFF_CON1 12'h008
`define SSP_OFF_CON3 12'h00C
`define SSP_OFF_ADD 12'h010
`define SSP_OFF_FLAG 12'h014

// Control one fields
`define SSP_CON1_WRITE_COLLISION_FLAG 7
`define SSP_CON1_EN 5
`define SSP_CON1_CKP 4
// Status fields
`define SSP_STAT_SMP 7
`define SSP_STAT_CKE 6
`define SSP_STAT_BF 0
// Control three fields
`define SSP_CON3_BOEN 4

// Mode codes in control one bits 3:0
`define SSP_MODE_M4 4'h0
`define SSP_MODE_M16 4'h1
`define SSP_MODE_M64 4'h2
`define SSP_MODE_MT2 4'h3
`define SSP_MODE_SSS 4'h4
`define SSP_MODE_SLV 4'h5
`define SSP_MODE_MADD 4'hA

// Reset values
`define SSP_CON1_RST 8'h00
`define SSP_STAT_RST 8'h00
`define SSP_ADD_RST 8'h00

// Divider cycle counts minus one per half serial clock (system clock = pclk)
`define SSP_HALF_M4 8'h01
`define SSP_HALF_M16 8'h07
`define SSP_HALF_M64 8'h1F

`endif

// >>> rtl/ssp_rate_gen.v
`timescale 1ns/1ps
`default_nettype none
`include "ssp_defines.vh"
// Master serial clock rate generator; pulses once per half serial bit
module ssp_rate_gen (
    // Clock and reset
    input wire pclk,
    input wire presetn,
    // Control
    input wire run,
    input wire [3:0] mode,
    input wire [7:0] reload,
    input wire t2_tick,
    // Half-bit enable
    output reg half_tick
);
    reg [8:0] cnt_reg;
    reg [8:0] limit;
    reg t2_half_reg;

    // Cycles per half period minus one; reload gives 2*(n+1) cycles
    always @* begin
        case (mode)
            `SSP_MODE_M4: limit = {1'b0, `SSP_HALF_M4};
            `SSP_MODE_M16: limit = {1'b0, `SSP_HALF_M16};
            `SSP_MODE_M64: limit = {1'b0, `SSP_HALF_M64};
            `SSP_MODE_MADD: limit = {reload, 1'b1};
            default: limit = {1'b0, `SSP_HALF_M4};
        endcase
    end

    // Counter restarts whenever idle so the first half bit is full
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_reg <= 9'h000;
            half_tick <= 1'b0;
            t2_half_reg <= 1'b0;
        end else if (!run) begin
            cnt_reg <= 9'h000;
            half_tick <= 1'b0;
            t2_half_reg <= 1'b0;
        end else if (mode == `SSP_MODE_MT2) begin
            // Timer output over two: every second tick
            half_tick <= 1'b0;
            if (t2_tick) begin
                t2_half_reg <= ~t2_half_reg;
                half_tick <= t2_half_reg;
            end
        end else if (cnt_reg >= limit) begin
            cnt_reg <= 9'h000;
            half_tick <= 1'b1;
        end else begin
            cnt_reg <= cnt_reg + 9'h001;
            half_tick <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// >>> rtl/ssp_edge_det.v
`timescale 1ns/1ps
`default_nettype none
// Edge detector for the serial clock pin in slave mode
module ssp_edge_det (
    // Clock and reset
    input wire pclk,
    input wire presetn,
    // Sampled pin
    input wire sig,
    // Edges
    output wire rise,
    output wire fall
);
    reg last_reg;

    // Previous sample; pin is taken as synchronous already
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            last_reg <= 1'b0;
        end else begin
            last_reg <= sig;
        end
    end

    assign rise = sig & ~last_reg;
    assign fall = ~sig & last_reg;
endmodule
`default_nettype wire

// >>> verif/ssp_spi_port_sva.sv
`timescale 1ns/1ps
`default_nettype none
`include "ssp_defines.vh"
module ssp_spi_port_sva (
    // APB side
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire pslverr,
    // Serial pins
    input wire ss_n,
    input wire sck_out,
    input wire sck_oe,
    input wire sdo_oe,
    input wire transfer_done_flag
);
    logic [5:0] con1_sh;
    logic [1:0] stat_sh;
    logic [3:0] e;
    logic armed, flag_q, sck_q;
    wire acc = psel && penable && pwrite;
    wire en = con1_sh[5];
    wire mst = en && (con1_sh[3:0] < 4'h4 || con1_sh[3:0] == 4'hA);
    wire flag_clr = acc && paddr == `SSP_OFF_FLAG && pwdata[0];
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    ////////////////////////////////////////////////////////////////////////
    // Shadow of software settings; a busy window opened by any buffer write, accepted or not
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            con1_sh <= 6'h00;
            stat_sh <= 2'h0;
            e <= 4'h0;
            armed <= 1'b0;
            flag_q <= 1'b0;
            sck_q <= 1'b0;
        end else begin
            flag_q <= transfer_done_flag;
            sck_q <= sck_out;
            if (acc && paddr == `SSP_OFF_CON1) con1_sh <= pwdata[5:0];
            if (acc && paddr == `SSP_OFF_STAT) stat_sh <= pwdata[7:6];
            // The last rising edge and the done flag land together
            if (acc && paddr == `SSP_OFF_BUF && !armed) begin
                armed <= 1'b1;
                e <= 4'h0;
            end else begin
                if (transfer_done_flag && !flag_q) begin
                    armed <= 1'b0;
                end
                if (sck_oe && sck_q == con1_sh[4] &&
                    sck_out != con1_sh[4]) begin
                    e <= e + 4'h1;
                end
            end
        end
    end
    ////////////////////////////////////////////////////////////////////////
    port_off_a: assert property (!en |-> !sdo_oe && !sck_oe)
        else $error("pins driven while port disabled");
    sck_dir_a: assert property (sck_oe == mst)
        else $error("clock direction disagrees with mode");
    sdo_quiet_a: assert property (
        (en && con1_sh[3:0] == 4'h4 && ss_n)[*4] |-> !sdo_oe)
        else $error("unselected slave drives data");
    done_sticky_a: assert property (
        transfer_done_flag && !flag_clr |=> transfer_done_flag)
        else $error("done flag dropped without clear");
    bad_addr_a: assert property (
        psel && penable && paddr > `SSP_OFF_FLAG |-> pslverr)
        else $error("unmapped access not refused");
    stat_read_a: assert property (
        psel && !penable && !pwrite && paddr == `SSP_OFF_STAT
        |=> prdata[7:6] == stat_sh && prdata[5:1] == 5'h00)
        else $error("status read disagrees with settings");
    clk_burst_a: assert property (
        sck_oe && sck_q == con1_sh[4] && sck_out != con1_sh[4]
        |-> armed && e < 4'h8)
        else $error("clock pulse outside a byte");
    byte_len_a: assert property (
        $rose(transfer_done_flag) && mst |=> e == 4'h8)
        else $error("byte done after wrong pulse count");
    sck_idle_a: assert property (
        sck_oe && !armed && $past(sck_oe) && $stable(con1_sh[4])
        |-> sck_out == con1_sh[4])
        else $error("idle clock not at polarity level");
endmodule
bind ssp_spi_port ssp_spi_port_sva chk (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pslverr(pslverr), .ss_n(ss_n),
    .sck_out(sck_out), .sck_oe(sck_oe), .sdo_oe(sdo_oe),
    .transfer_done_flag(transfer_done_flag));
`default_nettype wire

// >>> verif/ssp_spi_peer.sv
`timescale 1ns/1ps
`default_nettype none
// Far-side slave: idle-low clock, data out on falling, captured on rising
module ssp_spi_peer (
    // Bus
    input wire logic sck,
    input wire logic mosi,
    output logic miso,
    // Bench side
    input wire logic [7:0] tx_byte,
    input wire logic load,
    output logic [7:0] rx_byte
);
    logic [7:0] sh = 8'h00;
    // Spent bits refill with a toggling pattern, never the last value
    always @(negedge sck or posedge load) begin
        if (load) sh <= tx_byte;
        else sh <= {sh[6:0], ~sh[0]};
    end
    // Capture on the opposite edge, new bit enters at the bottom
    always @(posedge sck) rx_byte <= {rx_byte[6:0], mosi};
    assign miso = sh[7];
endmodule
`default_nettype wire

// >>> verif/tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "ssp_defines.vh"
module tb;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err, ld = 1'b0;
    logic t2_tick = 1'b0, tb_sck = 1'b0, tb_sdi = 1'b0, ss_n = 1'b1;
    logic slv = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, q;
    logic [7:0] ptx = 8'h00, got;
    logic [3:0] modes [5] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'hA};
    wire [31:0] prdata;
    wire [7:0] prx;
    wire pready, pslverr, sck_out, sck_oe, sdo_out, sdo_oe, done, miso;
    int n_mismatch = 0, samples_checked = 0;
    // Pin level: the port's clock wins when the port drives it
    wire sck_w = sck_oe ? sck_out : tb_sck;
    wire sdi_w = slv ? tb_sdi : miso;
    always #5 pclk = ~pclk;
    // Timer tick on every other cycle
    always @(posedge pclk) t2_tick <= ~t2_tick;
    ssp_spi_port dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .t2_tick(t2_tick), .sck_in(sck_w), .sck_out(sck_out),
        .sck_oe(sck_oe), .sdi(sdi_w), .sdo_out(sdo_out), .sdo_oe(sdo_oe),
        .ss_n(ss_n), .transfer_done_flag(done));
    ssp_spi_peer peer (.sck(sck_w), .mosi(sdo_out), .miso(miso),
        .tx_byte(ptx), .load(ld), .rx_byte(prx));
    ////////////////////////////////////////////////////////////////////////
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] ex,
                       input logic [31:0] gt);
        samples_checked++;
        if (gt !== ex) begin
            $display("mismatch %s expected %h seen %h", nm, ex, gt);
            n_mismatch++;
        end
    endtask
    // One APB transfer; held until pready is seen high
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rdc(input string nm, input logic [11:0] a,
                       input logic [31:0] ex);
        apb(1'b0, a, 32'h0);
        chk(nm, ex, q);
    endtask
    task automatic start(input logic [7:0] tx, input logic [7:0] rx);
        ptx <= rx;
        ld <= 1'b1;
        @(posedge pclk);
        ld <= 1'b0;
        apb(1'b1, `SSP_OFF_BUF, {24'h0, tx});
    endtask
    // Completion, buffer full, received byte, then flag cleared
    task automatic finish(input logic [7:0] tx, input logic [7:0] rx);
        for (int i = 0; i < 3000 && done !== 1'b1; i++) @(posedge pclk);
        rdc("full set", `SSP_OFF_STAT, 32'h41);
        rdc("rx byte", `SSP_OFF_BUF, {24'h0, rx});
        rdc("full clear", `SSP_OFF_STAT, 32'h40);
        chk("peer rx", {24'h0, tx}, {24'h0, prx});
        apb(1'b1, `SSP_OFF_FLAG, 32'h1);
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        rdc("stat rst", `SSP_OFF_STAT, 32'h0);
        rdc("con1 rst", `SSP_OFF_CON1, 32'h0);
        rdc("reload rst", `SSP_OFF_ADD, 32'h0);
        rdc("unmapped", 12'h018, 32'h0);
        chk("slverr", 32'h1, {31'h0, err});
        apb(1'b1, `SSP_OFF_STAT, 32'hFF);
        rdc("stat rw", `SSP_OFF_STAT, 32'hC0);
        apb(1'b1, `SSP_OFF_STAT, 32'h40);
        apb(1'b1, `SSP_OFF_ADD, 32'h1);
        $display("test registers done");
        // Every master rate, reconfigured with the port off
        for (int i = 0; i < 5; i++) begin
            apb(1'b1, `SSP_OFF_CON1, 32'h0);
            apb(1'b1, `SSP_OFF_CON1, {28'h2, modes[i]});
            start(8'hA5 ^ 8'(i), 8'h3C + 8'(i));
            finish(8'hA5 ^ 8'(i), 8'h3C + 8'(i));
        end
        $display("test master rates done");
        // A second write in flight is dropped and flagged
        start(8'h11, 8'h5A);
        apb(1'b1, `SSP_OFF_BUF, 32'h22);
        rdc("collision", `SSP_OFF_CON1, 32'hAA);
        finish(8'h11, 8'h5A);
        apb(1'b1, `SSP_OFF_BUF, 32'h33);
        repeat (50) @(posedge pclk);
        chk("blocked", 32'h0, {31'h0, done});
        apb(1'b1, `SSP_OFF_CON1, 32'h0);
        apb(1'b1, `SSP_OFF_BUF, 32'h55);
        repeat (50) @(posedge pclk);
        chk("off idle", 32'h0, {31'h0, done});
        $display("test collision done");
        // Slave with select: we clock eight bits in and out
        slv <= 1'b1;
        apb(1'b1, `SSP_OFF_CON1, 32'h24);
        @(negedge pclk);
        chk("unselected", 32'h0, {31'h0, sdo_oe});
        apb(1'b1, `SSP_OFF_BUF, 32'h96);
        ss_n <= 1'b0;
        repeat (8) @(posedge pclk);
        for (int i = 7; i >= 0; i--) begin
            tb_sdi <= 1'((8'hC3 >> i) & 1);
            repeat (8) @(posedge pclk);
            got = {got[6:0], sdo_out};
            tb_sck <= 1'b1;
            repeat (8) @(posedge pclk);
            tb_sck <= 1'b0;
        end
        repeat (8) @(posedge pclk);
        ss_n <= 1'b1;
        chk("slave tx", 32'h96, {24'h0, got});
        chk("slave done", 32'h1, {31'h0, done});
        rdc("slave rx", `SSP_OFF_BUF, 32'hC3);
        $display("test slave done");
        tally_and_finish;
    end
    // Watchdog well beyond the expected run
    initial begin
        repeat (60000) @(posedge pclk);
        n_mismatch++;
        tally_and_finish;
    end
endmodule
`default_nettype wire
